// File: dtc_pkg.sv
// dtc_pkg: constants and carrier types for the dual timer/counter block
package dtc_pkg;

  // register addresses and reset values
  localparam logic [7:0] ADDR_CTRL_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
  localparam logic [7:0] ADDR_CLK_SEL = 8'h8E;
  localparam logic [7:0] RST_CTRL_FLAGS = 8'h00;
  localparam logic [7:0] RST_MODE_SEL = 8'h00;
  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic [7:0] CLK_SEL_MASK = 8'h1B;
  localparam logic [7:0] READ_NONE = 8'h00;

  // timer modes
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_8RL = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // prescale choices and terminal counts (divide minus one)
  localparam logic [1:0] PS_DIV12 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV48 = 2'h2;
  localparam logic [1:0] PS_EXT8 = 2'h3;
  localparam logic [5:0] TERM_DIV12 = 6'h0B;
  localparam logic [5:0] TERM_DIV4 = 6'h03;
  localparam logic [5:0] TERM_DIV48 = 6'h2F;
  localparam logic [2:0] TERM_EXT8 = 3'h7;

  // count limits
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [12:0] CNT13_MAX = 13'h1FFF;
  localparam logic [15:0] CNT16_MAX = 16'hFFFF;

  // timer byte load selects
  localparam logic [1:0] SEL_T0_LO = 2'h0;
  localparam logic [1:0] SEL_T0_HI = 2'h1;
  localparam logic [1:0] SEL_T1_LO = 2'h2;
  localparam logic [1:0] SEL_T1_HI = 2'h3;

  // pin positions inside the synchroniser vectors
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_FIRST_EXT_IRQ_PIN_N = 2;
  localparam int PIN_SECOND_EXT_IRQ_PIN_N = 3;

  typedef struct packed {
    logic tf1, tr1, tf0, tr0, ie1, it1, ie0, it0;
  } dtc_ctrl_t;

  typedef struct packed {
    logic second_timer_pin_gating, ct1;
    logic [1:0] mode1;
    logic first_timer_pin_gating, ct0;
    logic [1:0] mode0;
  } dtc_mode_t;

  typedef struct packed {
    logic [2:0] unused_hi;
    logic t1m, t0m;
    logic unused_b2;
    logic [1:0] sca;
  } dtc_clk_t;

  typedef struct packed {
    logic [7:0] hi, lo;
  } dtc_pair_t;

  typedef struct packed {
    dtc_pair_t pair;
    logic ovf;
  } dtc_cnt_t;

  typedef struct packed {
    logic [7:0] addr, wdata;
    logic wr, rd;
  } dtc_sfr_req_t;

  typedef struct packed {
    logic wr;
    logic [1:0] sel;
    logic [7:0] data;
  } dtc_load_t;

  typedef struct packed {
    dtc_ctrl_t ctrl;
    dtc_mode_t mode;
    dtc_clk_t ckc;
    dtc_pair_t t0, t1;
    logic [3:0] s1, s2, s3;
    logic [2:0] ext_sync;
    logic [5:0] presc_cnt;
    logic [2:0] ext_cnt;
    logic [7:0] rdata;
    logic t1_ovf;
  } dtc_state_t;

endpackage

// File: dtc_timer_top.sv
// dtc_timer_top: two counter/timers, prescaler, external interrupt flags
`timescale 1ns/1ps
module dtc_timer_top
(
  // clock and reset
  input logic clk,
  input logic rst,
  // special function register access
  input dtc_pkg::dtc_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // timer byte loads from the core
  input dtc_pkg::dtc_load_t byte_load,
  // pins, all asynchronous to clk
  input logic first_count_pin,
  input logic second_count_pin,
  input logic first_ext_irq_pin_n,
  input logic second_ext_irq_pin_n,
  input logic ext_clk_in,
  // vector acknowledges from the interrupt controller
  input logic first_timer_vector_ack,
  input logic second_timer_vector_ack,
  input logic first_ext_irq_vector_ack,
  input logic second_ext_irq_vector_ack,
  // flags and counts
  output logic first_timer_overflow_flag,
  output logic second_timer_overflow_flag,
  output logic first_ext_irq_flag,
  output logic second_ext_irq_flag,
  output dtc_pkg::dtc_pair_t first_timer_count,
  output dtc_pkg::dtc_pair_t second_timer_count,
  output logic second_timer_overflow_pulse
);

  dtc_pkg::dtc_state_t s; // registered state
  dtc_pkg::dtc_state_t next_s; // next state
  dtc_pkg::dtc_cnt_t step0; // first timer step result
  dtc_pkg::dtc_cnt_t step1; // second timer step result
  logic [3:0] fall; // falling edges of synchronised pins
  logic ext_rise; // rising edge of synchronised external clock
  logic presc_tick; // shared prescaled clock tick
  logic [5:0] presc_term; // terminal count of internal divider
  logic t0_clk, t1_clk; // timer-function clocks
  logic t0_inc, th_inc, t1_inc; // increment strobes
  logic split; // first timer in split mode
  logic ovf0, ovf_hi; // first timer low and split high overflow

  // one step of a timer pair in modes 0, 1 and 2
  function automatic dtc_pkg::dtc_cnt_t count_step
  (
    input dtc_pkg::dtc_pair_t p,
    input logic [1:0] mode
  );
    dtc_pkg::dtc_cnt_t r;
    logic [12:0] c13;
    logic [15:0] c16;
    r.pair = p;
    r.ovf = 1'b0;
    c13 = {p.hi, p.lo[4:0]};
    c16 = {p.hi, p.lo};
    case (mode)
      dtc_pkg::MODE_13:
      begin
        r.ovf = (c13 == dtc_pkg::CNT13_MAX);
        c13 = c13 + 13'h0001;
        r.pair.hi = c13[12:5];
        // upper low bits are left as they were
        r.pair.lo[4:0] = c13[4:0];
      end
      dtc_pkg::MODE_16:
      begin
        r.ovf = (c16 == dtc_pkg::CNT16_MAX);
        c16 = c16 + 16'h0001;
        r.pair = c16;
      end
      default:
      begin
        r.ovf = (p.lo == dtc_pkg::BYTE_MAX);
        r.pair.lo = r.ovf ? p.hi : p.lo + 8'h01;
      end
    endcase
    return r;
  endfunction

  // all next-state logic
  always_comb
  begin
    next_s = s;
    next_s.s1 = {second_ext_irq_pin_n, first_ext_irq_pin_n,
                 second_count_pin, first_count_pin};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // s1 feeds only s2; edges come from s2 against s3
    fall = s.s3 & ~s.s2;
    next_s.ext_sync = {s.ext_sync[1:0], ext_clk_in};
    ext_rise = s.ext_sync[1] & ~s.ext_sync[2];

    unique case (s.ckc.sca)
      dtc_pkg::PS_DIV12: presc_term = dtc_pkg::TERM_DIV12;
      dtc_pkg::PS_DIV4: presc_term = dtc_pkg::TERM_DIV4;
      dtc_pkg::PS_DIV48: presc_term = dtc_pkg::TERM_DIV48;
      dtc_pkg::PS_EXT8: presc_term = dtc_pkg::TERM_DIV12;
    endcase
    if (s.ckc.sca == dtc_pkg::PS_EXT8)
    begin
      // one tick per eight external clock rises
      presc_tick = ext_rise && (s.ext_cnt == dtc_pkg::TERM_EXT8);
      next_s.presc_cnt = '0;
      if (ext_rise)
      begin
        next_s.ext_cnt = s.ext_cnt + 3'h1;
      end
    end
    else
    begin
      // >= keeps a shrunken divide from running past its end
      presc_tick = (s.presc_cnt >= presc_term);
      next_s.presc_cnt = presc_tick ? 6'h00 : s.presc_cnt + 6'h01;
      next_s.ext_cnt = '0;
    end

    t0_clk = s.ckc.t0m | presc_tick;
    t1_clk = s.ckc.t1m | presc_tick;
    split = (s.mode.mode0 == dtc_pkg::MODE_SPLIT);

    t0_inc = s.ctrl.tr0 & (~s.mode.first_timer_pin_gating | s.s2[dtc_pkg::PIN_FIRST_EXT_IRQ_PIN_N])
             & (s.mode.ct0 ? fall[dtc_pkg::PIN_T0] : t0_clk);
    // split high byte on second run bit, internal clock
    th_inc = split & s.ctrl.tr1 & t0_clk;
    // mode three stops the second timer
    if (split)
    begin
      // free running on internal clock only
      t1_inc = (s.mode.mode1 != dtc_pkg::MODE_SPLIT) & t1_clk;
    end
    else
    begin
      // same controls as the first timer
      t1_inc = (s.mode.mode1 != dtc_pkg::MODE_SPLIT) & s.ctrl.tr1
               & (~s.mode.second_timer_pin_gating | s.s2[dtc_pkg::PIN_SECOND_EXT_IRQ_PIN_N])
               & (s.mode.ct1 ? fall[dtc_pkg::PIN_T1] : t1_clk);
    end

    // first timer counting
    step0 = count_step(s.t0, s.mode.mode0);
    ovf0 = 1'b0;
    ovf_hi = 1'b0;
    if (split)
    begin
      // low byte as plain eight bit counter
      if (t0_inc)
      begin
        ovf0 = (s.t0.lo == dtc_pkg::BYTE_MAX);
        next_s.t0.lo = s.t0.lo + 8'h01;
      end
      if (th_inc)
      begin
        ovf_hi = (s.t0.hi == dtc_pkg::BYTE_MAX);
        next_s.t0.hi = s.t0.hi + 8'h01;
      end
    end
    else if (t0_inc)
    begin
      next_s.t0 = step0.pair;
      ovf0 = step0.ovf;
    end

    // second timer counting
    step1 = count_step(s.t1, s.mode.mode1);
    next_s.t1_ovf = t1_inc & step1.ovf;
    if (t1_inc)
    begin
      next_s.t1 = step1.pair;
    end

    // byte loads win over counting, run bit never clears
    if (byte_load.wr)
    begin
      unique case (byte_load.sel)
        dtc_pkg::SEL_T0_LO: next_s.t0.lo = byte_load.data;
        dtc_pkg::SEL_T0_HI: next_s.t0.hi = byte_load.data;
        dtc_pkg::SEL_T1_LO: next_s.t1.lo = byte_load.data;
        dtc_pkg::SEL_T1_HI: next_s.t1.hi = byte_load.data;
      endcase
    end

    next_s.ctrl.tf0 = s.ctrl.tf0 & ~first_timer_vector_ack;
    next_s.ctrl.tf1 = s.ctrl.tf1 & ~second_timer_vector_ack;
    next_s.ctrl.ie0 = s.ctrl.ie0 & ~(s.ctrl.it0 & first_ext_irq_vector_ack);
    next_s.ctrl.ie1 = s.ctrl.ie1 & ~(s.ctrl.it1 & second_ext_irq_vector_ack);

    // register writes
    if (sfr_req.wr)
    begin
      unique case (sfr_req.addr)
        dtc_pkg::ADDR_CTRL_FLAGS: next_s.ctrl = sfr_req.wdata;
        dtc_pkg::ADDR_MODE_SEL: next_s.mode = sfr_req.wdata;
        dtc_pkg::ADDR_CLK_SEL:
          next_s.ckc = sfr_req.wdata & dtc_pkg::CLK_SEL_MASK;
        default: ;
      endcase
    end

    // hardware sets come last so an event beats a clear
    next_s.ctrl.tf0 = next_s.ctrl.tf0 | ovf0;
    // second timer overflow sets no flag in split mode; its pulse still fires
    next_s.ctrl.tf1 = next_s.ctrl.tf1 | (split ? ovf_hi : next_s.t1_ovf);
    // type bit picks edge or level source
    if (s.ctrl.it0)
    begin
      next_s.ctrl.ie0 = next_s.ctrl.ie0 | fall[dtc_pkg::PIN_FIRST_EXT_IRQ_PIN_N];
    end
    else
    begin
      // level mode follows the inverse of the pin
      next_s.ctrl.ie0 = ~s.s2[dtc_pkg::PIN_FIRST_EXT_IRQ_PIN_N];
    end
    if (s.ctrl.it1)
    begin
      next_s.ctrl.ie1 = next_s.ctrl.ie1 | fall[dtc_pkg::PIN_SECOND_EXT_IRQ_PIN_N];
    end
    else
    begin
      next_s.ctrl.ie1 = ~s.s2[dtc_pkg::PIN_SECOND_EXT_IRQ_PIN_N];
    end

    // register reads, answered one cycle later
    if (sfr_req.rd)
    begin
      unique case (sfr_req.addr)
        dtc_pkg::ADDR_CTRL_FLAGS: next_s.rdata = s.ctrl;
        dtc_pkg::ADDR_MODE_SEL: next_s.rdata = s.mode;
        dtc_pkg::ADDR_CLK_SEL: next_s.rdata = s.ckc;
        default: next_s.rdata = dtc_pkg::READ_NONE;
      endcase
    end
  end

  // state register; reset loads constants only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.ctrl <= dtc_pkg::RST_CTRL_FLAGS;
      s.mode <= dtc_pkg::RST_MODE_SEL;
      s.ckc <= dtc_pkg::RST_CLK_SEL;
      // idle pins sit high, so no false edge after reset
      s.s1 <= 4'hF;
      s.s2 <= 4'hF;
      s.s3 <= 4'hF;
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign sfr_rdata = s.rdata;
  assign first_timer_overflow_flag = s.ctrl.tf0;
  assign second_timer_overflow_flag = s.ctrl.tf1;
  assign first_ext_irq_flag = s.ctrl.ie0;
  assign second_ext_irq_flag = s.ctrl.ie1;
  assign first_timer_count = s.t0;
  assign second_timer_count = s.t1;
  assign second_timer_overflow_pulse = s.t1_ovf;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic quiet; // no write, load or timer vector ack this cycle
  assign quiet = ~sfr_req.wr & ~byte_load.wr & ~first_timer_vector_ack
                 & ~second_timer_vector_ack;

  a_mode0_wrap: assert property (
    (s.mode.mode0 == dtc_pkg::MODE_13) && t0_inc && quiet
    && ({s.t0.hi, s.t0.lo[4:0]} == dtc_pkg::CNT13_MAX)
    |=> s.ctrl.tf0 && (s.t0.hi == 8'h00) && (s.t0.lo[4:0] == 5'h00))
    else $error("mode 0 wrap did not set flag or clear count");

  a_mode0_carry: assert property (
    (s.mode.mode0 == dtc_pkg::MODE_13) && t0_inc && quiet
    && (s.t0.lo[4:0] == 5'h1F) && (s.t0.hi != dtc_pkg::BYTE_MAX)
    |=> s.t0.hi == $past(s.t0.hi) + 8'h01)
    else $error("mode 0 low five bits did not carry into high byte");

  a_mode2_reload: assert property (
    (s.mode.mode0 == dtc_pkg::MODE_8RL) && t0_inc && quiet
    && (s.t0.lo == dtc_pkg::BYTE_MAX)
    |=> (s.t0.lo == $past(s.t0.hi)) && $stable(s.t0.hi) && s.ctrl.tf0)
    else $error("mode 2 reload wrong");

  a_run_hold: assert property (
    !s.ctrl.tr0 && !split && !byte_load.wr ##1 !s.ctrl.tr0
    |-> $stable(s.t0))
    else $error("first timer moved while stopped");

  a_gate_block: assert property (
    s.mode.first_timer_pin_gating && !s.s2[dtc_pkg::PIN_FIRST_EXT_IRQ_PIN_N] |-> !t0_inc)
    else $error("gated timer counted while pin low");

  a_pin_count: assert property (
    s.mode.ct0 && s.ctrl.tr0 && !s.mode.first_timer_pin_gating
    |-> t0_inc == (s.s3[dtc_pkg::PIN_T0] && !s.s2[dtc_pkg::PIN_T0]))
    else $error("counter function not tied to pin fall");

  a_div4_period: assert property (
    presc_tick && (s.ckc.sca == dtc_pkg::PS_DIV4)
    ##1 (s.ckc.sca == dtc_pkg::PS_DIV4 && !presc_tick) [*3]
    ##1 (s.ckc.sca == dtc_pkg::PS_DIV4)
    |-> presc_tick)
    else $error("divide by four tick spacing wrong");

  a_clk_unused: assert property (
    sfr_req.rd && (sfr_req.addr == dtc_pkg::ADDR_CLK_SEL)
    |=> (sfr_rdata & ~dtc_pkg::CLK_SEL_MASK) == 8'h00)
    else $error("unused clock select bits read nonzero");

  a_ack_clear: assert property (
    first_timer_vector_ack && !sfr_req.wr && !t0_inc
    |=> !s.ctrl.tf0)
    else $error("vector did not clear first overflow flag");

  a_level_flag: assert property (
    !s.ctrl.it0 && !s.s2[dtc_pkg::PIN_FIRST_EXT_IRQ_PIN_N] |=> s.ctrl.ie0)
    else $error("level flag not set while pin low");

  a_split_high: assert property (
    th_inc && (s.t0.hi == dtc_pkg::BYTE_MAX) |=> s.ctrl.tf1)
    else $error("split high overflow did not set second flag");

  a_split_t1: assert property (
    split && !s.ctrl.tf1 && !ovf_hi && !sfr_req.wr |=> !s.ctrl.tf1)
    else $error("second timer set its flag in split mode");

  c_reload: cover property (
    (s.mode.mode0 == dtc_pkg::MODE_8RL) && t0_inc
    && (s.t0.lo == dtc_pkg::BYTE_MAX));
  c_split_ovf: cover property (th_inc && (s.t0.hi == dtc_pkg::BYTE_MAX));
  c_edge_flag: cover property (s.ctrl.it1 && fall[dtc_pkg::PIN_SECOND_EXT_IRQ_PIN_N]);
  c_ext_tick: cover property (
    presc_tick && (s.ckc.sca == dtc_pkg::PS_EXT8));

endmodule

// File: dtc_pin_model.sv
// dtc_pin_model: far-side driver of count, gate/irq and external clock pins
`timescale 1ns/1ps
module dtc_pin_model
(
  // clock used to pace pin changes
  input wire logic clk,
  // pins toward the timer block
  output logic first_count_pin,
  output logic second_count_pin,
  output logic first_ext_irq_pin_n,
  output logic second_ext_irq_pin_n,
  output logic ext_clk_in
);
  // pins idle high; ext clock parked low, it only runs in bursts
  initial
  begin
    first_count_pin = 1'h1;
    second_count_pin = 1'h1;
    first_ext_irq_pin_n = 1'h1;
    second_ext_irq_pin_n = 1'h1;
    ext_clk_in = 1'h0;
  end
  task automatic count_falls(input int n);
    repeat (n)
    begin
      first_count_pin = 1'h0;
      second_count_pin = 1'h0;
      repeat (3) @(negedge clk);
      first_count_pin = 1'h1;
      second_count_pin = 1'h1;
      repeat (3) @(negedge clk);
    end
  endtask
  // gate and interrupt pin level, both pins together
  task automatic set_irq(input logic lvl);
    first_ext_irq_pin_n = lvl;
    second_ext_irq_pin_n = lvl;
  endtask
  // 12 ns period, no phase relation to clk
  task automatic ext_burst(input int n);
    #1.3;
    repeat (n)
    begin
      #6 ext_clk_in = 1'h1;
      #6 ext_clk_in = 1'h0;
    end
  endtask
endmodule

// File: dual_timer_counter_four_modes_test.sv
// dual_timer_counter_four_modes_test: self-checking bench of the timer block
`timescale 1ns/1ps
module dual_timer_counter_four_modes_test;
  // stimulus toward the block
  logic clk = 1'h0;
  logic rst = 1'h1;
  dtc_pkg::dtc_sfr_req_t sfr_req = '0;
  dtc_pkg::dtc_load_t byte_load = '0;
  logic [3:0] ack = 4'h0;
  // observed outputs; fl packs tf1, tf0, ie1, ie0
  logic [7:0] sfr_rdata;
  logic tf0, tf1, ie0, ie1;
  logic cp0, cp1, ip0, ip1, ext_clk;
  dtc_pkg::dtc_pair_t cnt0, cnt1;
  logic [3:0] fl;
  logic [7:0] v;
  logic t1p; // second timer wrap pulse
  int n_t1p = 0; // wrap pulses seen so far
  int n_mismatch = 0;
  int comparisons = 0;
  assign fl = {tf1, tf0, ie1, ie0};
  // the pulse stands one cycle, so the falling edge sees it once
  always @(negedge clk)
    if (t1p === 1'h1)
      n_t1p++;
  // free-running 250 MHz clock
  always #2 clk = ~clk;
  dtc_timer_top dtc_timer_top_inst (.clk(clk), .rst(rst),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .byte_load(byte_load),
    .first_count_pin(cp0), .second_count_pin(cp1),
    .first_ext_irq_pin_n(ip0), .second_ext_irq_pin_n(ip1),
    .ext_clk_in(ext_clk), .first_timer_vector_ack(ack[0]),
    .second_timer_vector_ack(ack[1]), .first_ext_irq_vector_ack(ack[2]),
    .second_ext_irq_vector_ack(ack[3]),
    .first_timer_overflow_flag(tf0), .second_timer_overflow_flag(tf1),
    .first_ext_irq_flag(ie0), .second_ext_irq_flag(ie1),
    .first_timer_count(cnt0), .second_timer_count(cnt1),
    .second_timer_overflow_pulse(t1p));
  dtc_pin_model dtc_pin_model_inst (.clk(clk), .first_count_pin(cp0),
    .second_count_pin(cp1), .first_ext_irq_pin_n(ip0),
    .second_ext_irq_pin_n(ip1), .ext_clk_in(ext_clk));
  // compare and count
  task automatic check(input logic [15:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  // bus tasks start at a falling edge and leave one idle cycle after,
  // so a strobe is never dropped and raised in the same time step
  task automatic wr_reg(input logic [7:0] a, d);
    sfr_req = '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(negedge clk);
    sfr_req.wr = 1'h0;
    @(negedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    sfr_req = '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(negedge clk);
    sfr_req.rd = 1'h0;
    v = sfr_rdata;
    @(negedge clk);
  endtask
  task automatic load(input logic [1:0] s, input logic [7:0] d);
    byte_load = '{wr: 1'h1, sel: s, data: d};
    @(negedge clk);
    byte_load.wr = 1'h0;
    @(negedge clk);
  endtask
  task automatic pulse_ack(input int i);
    ack[i] = 1'h1;
    @(negedge clk);
    ack[i] = 1'h0;
    @(negedge clk);
  endtask
  // stop both timers; writing back seen overflow flags keeps them (software set)
  task automatic stop;
    wr_reg(8'h88, {tf1, 1'h0, tf0, 5'h00});
  endtask
  // run m+2 counting edges with the given control byte
  task automatic run(input logic [7:0] ctl, input int m);
    wr_reg(8'h88, ctl);
    repeat (m) @(negedge clk);
    stop;
  endtask
  task automatic setup(input logic [7:0] md, ck, input logic [15:0] c);
    wr_reg(8'h89, md);
    wr_reg(8'h8E, ck);
    load(2'h1, c[15:8]);
    load(2'h0, c[7:0]);
  endtask
  task automatic t_regs;
    logic [7:0] a[3] = '{8'h88, 8'h89, 8'h8E};
    foreach (a[i])
    begin
      rd_reg(a[i]);
      check({8'h00, v}, 16'h0000, "reset value");
    end
    wr_reg(8'h8E, 8'hFF);
    rd_reg(8'h8E);
    check({8'h00, v}, 16'h001B, "unused bits");
    wr_reg(8'h89, 8'hA5);
    rd_reg(8'h89);
    check({8'h00, v}, 16'h00A5, "mode reg");
    wr_reg(8'h8F, 8'h5A);
    rd_reg(8'h8F);
    check({8'h00, v}, 16'h0000, "unmapped");
    $display("test regs done");
  endtask
  // 13-bit wrap then flag cleared by vectoring
  task automatic t_mode0;
    setup(8'h00, 8'h08, 16'hFFFE);
    run(8'h10, 0);
    check({cnt0.hi, 3'h0, cnt0.lo[4:0]}, 16'h0000, "13b wrap");
    check({12'h0, fl}, 16'h0004, "13b flag");
    pulse_ack(0);
    check({12'h0, fl}, 16'h0000, "vector clear");
    $display("test mode0 done");
  endtask
  task automatic t_mode1;
    setup(8'h01, 8'h08, 16'hFFFF);
    run(8'h10, 0);
    check(cnt0, 16'h0001, "16b wrap");
    check({12'h0, fl}, 16'h0004, "16b flag");
    wr_reg(8'h88, 8'h00);
    check({12'h0, fl}, 16'h0000, "sw clear");
    $display("test mode1 done");
  endtask
  // second timer auto-reload through one wrap
  task automatic t_mode2;
    int p0;
    wr_reg(8'h89, 8'h20);
    wr_reg(8'h8E, 8'h10);
    load(2'h3, 8'h80);
    load(2'h2, 8'hFE);
    p0 = n_t1p;
    run(8'h40, 1);
    check(cnt1, 16'h8081, "reload");
    check({12'h0, fl}, 16'h0008, "t1 flag");
    check(16'(n_t1p - p0), 16'h0001, "wrap pulse");
    pulse_ack(1);
    $display("test mode2 done");
  endtask
  // split: high byte waits for second run bit
  task automatic t_split;
    setup(8'h03, 8'h18, 16'hFEFE);
    load(2'h3, 8'hFF);
    load(2'h2, 8'hFF);
    run(8'h10, 0);
    check(cnt0, 16'hFE00, "low only");
    check({12'h0, fl}, 16'h0004, "no t1 flag");
    // keep the low byte's flag set while the high byte runs
    run(8'h60, 0);
    check({8'h00, cnt0.hi}, 16'h0000, "high wrap");
    check({12'h0, fl}, 16'h000C, "high flag");
    wr_reg(8'h88, 8'h00);
    $display("test split done");
  endtask
  // both count pins; clock selects set but ignored in counter function
  task automatic t_count;
    setup(8'h55, 8'h18, 16'h0000);
    load(2'h3, 8'h00);
    load(2'h2, 8'h00);
    wr_reg(8'h88, 8'h50);
    dtc_pin_model_inst.count_falls(3);
    repeat (6) @(negedge clk);
    stop;
    check(cnt0, 16'h0003, "pin falls");
    check(cnt1, 16'h0003, "second pin falls");
    $display("test count done");
  endtask
  task automatic t_gate;
    setup(8'h09, 8'h08, 16'h0000);
    dtc_pin_model_inst.set_irq(1'h0);
    repeat (4) @(negedge clk);
    run(8'h10, 20);
    check(cnt0, 16'h0000, "gated");
    check({12'h0, fl}, 16'h0003, "level flag");
    dtc_pin_model_inst.set_irq(1'h1);
    repeat (4) @(negedge clk);
    run(8'h10, 10);
    check(cnt0, 16'h000C, "ungated");
    check({12'h0, fl}, 16'h0000, "level low");
    wr_reg(8'h88, 8'h05);
    dtc_pin_model_inst.set_irq(1'h0);
    repeat (6) @(negedge clk);
    dtc_pin_model_inst.set_irq(1'h1);
    repeat (6) @(negedge clk);
    check({12'h0, fl}, 16'h0003, "edge latch");
    pulse_ack(2);
    check({12'h0, fl}, 16'h0002, "edge vector");
    pulse_ack(3);
    check({12'h0, fl}, 16'h0000, "second vector");
    wr_reg(8'h88, 8'h00);
    $display("test gate done");
  endtask
  // prescaler ticks over exactly 48 counting edges, then ext/8
  task automatic t_presc;
    int dv[3] = '{12, 4, 48};
    foreach (dv[i])
    begin
      setup(8'h01, 8'(i), 16'h0000);
      run(8'h10, 46);
      check(cnt0, 16'(48 / dv[i]), "prescale");
    end
    setup(8'h01, 8'h03, 16'h0000);
    wr_reg(8'h88, 8'h10);
    dtc_pin_model_inst.ext_burst(16);
    repeat (10) @(negedge clk);
    stop;
    check(cnt0, 16'h0002, "ext div8");
    $display("test prescale done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog well past the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    t_regs;
    t_mode0;
    t_mode1;
    t_mode2;
    t_split;
    t_count;
    t_gate;
    t_presc;
    end_of_test;
  end
endmodule
